// *** hdl/jip_pin_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module jip_pin_filter
  import jip_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] pin_in, // Raw pin levels.
  output logic [WIDTH-1:0] level_out // Filtered levels.
);

  logic [WIDTH-1:0] s1_reg, s1_next;
  logic [WIDTH-1:0] s2_reg, s2_next;
  logic [WIDTH-1:0] s3_reg, s3_next;
  logic [WIDTH-1:0] level_reg, level_next;

  // A change is accepted only once the second and third stages agree.
  always_comb
  begin
    s1_next = pin_in;
    s2_next = s1_reg;
    s3_next = s2_reg;
    level_next = level_reg;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_reg[i] == s3_reg[i])
      begin
        level_next[i] = s3_reg[i];
      end
    end
  end

  // Registers the sampling chain.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level_reg <= '0;
    end
    else
    begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

endmodule
`default_nettype wire

// *** hdl/jip_port.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Port on when any enable condition true.
// - Pins inputs until enable command; then TDO.
// - Port off releases pins to general I/O.
// - Configuration bit dedicates pins permanently.
// - Register at offset C7h enables port.
// - Device reset or zero write clears enable.
// - Product term is third enable condition.
// - Dedicated pins: reset never aborts operations.
// - Otherwise reset blocks and aborts operations.
// - Only configuration commands; no boundary scan.
// - Blank device enables port by default.
// - Enable command optionally turns on extensions.
// - Error low on failure until clear.
// - Status high while memory idle and readable.
// - Program flash arrays, logic and configuration.
// - Status low during program, erase, secondary write.
// - Extensions optionally open-drain for wired-OR.
module jip_port
  import jip_pkg::*;
(
  input wire logic clk, // System clock, 200 MHz.
  input wire logic rst_n, // Power-on reset, active low.
  input wire logic dev_reset_n, // Device reset, active low.
  input wire logic nvm_dedicate, // Non-volatile dedication bit.
  input wire logic device_blank, // Device is blank or erased.
  input wire logic enable_product_term, // Product term enable from logic array.
  input wire logic io_sel, // I/O block base selected.
  input wire logic [7:0] reg_addr, // Register offset.
  input wire logic reg_wr, // Register write strobe.
  input wire logic [7:0] reg_wdata, // Register write data.
  output logic [7:0] reg_rdata, // Register read data.
  input wire jip_tap_pins_type tap_pin_in, // Test mode, clock and data pins.
  input wire logic [3:0] gpio_out, // General I/O output values.
  input wire logic [3:0] gpio_oe_n, // General I/O enables, active low.
  output logic [3:0] pin_out, // Pin output values.
  output logic [3:0] pin_oe_n, // Pin enables, active low.
  output logic program_status_out, // Status extension value.
  output logic program_status_oe_n, // Status extension enable, active low.
  output logic program_error_out, // Error extension value.
  output logic program_error_oe_n, // Error extension enable, active low.
  input wire logic mem_busy, // Memory program or erase running.
  input wire logic prog_fail, // Program or erase failure pulse.
  output jip_prog_cmd_type prog_cmd, // Programming command fields.
  output logic prog_req, // Program request pulse.
  output logic erase_req // Erase request pulse.
);

  // Selects the long data register for data-bearing instructions.
  function automatic logic dr_is_data(input logic [7:0] ir);
    dr_is_data = (ir == JIP_ISC_PROGRAM) || (ir == JIP_ISC_ERASE) || (ir == JIP_ISC_ENABLE);
  endfunction

  jip_tap_pins_type tap_f;
  logic [2:0] tap_level;
  logic port_on, dedicated, abort, hold, tck_rise, tck_fall, reg_hit;
  logic err_clear;
  logic enable_reg, enable_next;
  logic tck_prev_reg, tck_prev_next;
  jip_tap_state_type tap_state_reg, tap_state_next;
  logic [7:0] ir_shift_reg, ir_shift_next, ir_reg, ir_next;
  logic [JIP_DR_W-1:0] dr_shift_reg, dr_shift_next;
  logic bypass_reg, bypass_next;
  logic active_reg, active_next, ext_en_reg, ext_en_next, od_reg, od_next;
  logic tdo_reg, tdo_next, tdo_drive_reg, tdo_drive_next;
  logic error_reg, error_next, disabled_seen_reg, disabled_seen_next;
  jip_prog_cmd_type prog_cmd_reg, prog_cmd_next;
  logic prog_req_reg, prog_req_next, erase_req_reg, erase_req_next;
  logic [3:0] pin_out_reg, pin_out_next, pin_oe_n_reg, pin_oe_n_next;
  logic st_out_reg, st_out_next, st_oe_n_reg, st_oe_n_next;
  logic er_out_reg, er_out_next, er_oe_n_reg, er_oe_n_next;

  jip_pin_filter #(
    .WIDTH(3)
  ) u_filter (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(tap_pin_in),
    .level_out(tap_level)
  );

  // Enable terms and test clock edges.
  always_comb
  begin
    tap_f = jip_tap_pins_type'(tap_level);
    dedicated = nvm_dedicate | device_blank;
    port_on = dedicated | enable_reg | enable_product_term;
    abort = ~dev_reset_n & ~dedicated;
    hold = ~port_on | abort;
    tck_rise = tap_f.tck & ~tck_prev_reg;
    tck_fall = ~tap_f.tck & tck_prev_reg;
    reg_hit = io_sel & (reg_addr == JIP_ENABLE_OFFSET);
    reg_rdata = reg_hit ? {7'h00, enable_reg} : 8'h00;
  end

  // Run-time enable register.
  always_comb
  begin
    enable_next = enable_reg;
    if (reg_hit && reg_wr)
    begin
      enable_next = reg_wdata[JIP_ENABLE_BIT];
    end
    if (!dev_reset_n)
    begin
      enable_next = 1'b0;
    end
  end

  // Test access port controller and its registers.
  always_comb
  begin
    tck_prev_next = tap_f.tck;
    tap_state_next = tap_state_reg;
    ir_shift_next = ir_shift_reg;
    ir_next = ir_reg;
    dr_shift_next = dr_shift_reg;
    bypass_next = bypass_reg;
    active_next = active_reg;
    ext_en_next = ext_en_reg;
    od_next = od_reg;
    tdo_next = tdo_reg;
    tdo_drive_next = tdo_drive_reg;
    disabled_seen_next = disabled_seen_reg;
    prog_cmd_next = prog_cmd_reg;
    prog_req_next = 1'b0;
    erase_req_next = 1'b0;
    err_clear = 1'b0;
    if (hold)
    begin
      tap_state_next = JIP_TLR;
      ir_next = JIP_BYPASS;
      active_next = 1'b0;
      ext_en_next = 1'b0;
      od_next = 1'b0;
      tdo_drive_next = 1'b0;
    end
    else if (tck_rise)
    begin
      case (tap_state_reg)
        JIP_TLR: tap_state_next = tap_f.tms ? JIP_TLR : JIP_RTI;
        JIP_RTI: tap_state_next = tap_f.tms ? JIP_SEL_DR : JIP_RTI;
        JIP_SEL_DR: tap_state_next = tap_f.tms ? JIP_SEL_IR : JIP_CAP_DR;
        JIP_CAP_DR: tap_state_next = tap_f.tms ? JIP_EX1_DR : JIP_SH_DR;
        JIP_SH_DR: tap_state_next = tap_f.tms ? JIP_EX1_DR : JIP_SH_DR;
        JIP_EX1_DR: tap_state_next = tap_f.tms ? JIP_UPD_DR : JIP_PA_DR;
        JIP_PA_DR: tap_state_next = tap_f.tms ? JIP_EX2_DR : JIP_PA_DR;
        JIP_EX2_DR: tap_state_next = tap_f.tms ? JIP_UPD_DR : JIP_SH_DR;
        JIP_UPD_DR: tap_state_next = tap_f.tms ? JIP_SEL_DR : JIP_RTI;
        JIP_SEL_IR: tap_state_next = tap_f.tms ? JIP_TLR : JIP_CAP_IR;
        JIP_CAP_IR: tap_state_next = tap_f.tms ? JIP_EX1_IR : JIP_SH_IR;
        JIP_SH_IR: tap_state_next = tap_f.tms ? JIP_EX1_IR : JIP_SH_IR;
        JIP_EX1_IR: tap_state_next = tap_f.tms ? JIP_UPD_IR : JIP_PA_IR;
        JIP_PA_IR: tap_state_next = tap_f.tms ? JIP_EX2_IR : JIP_PA_IR;
        JIP_EX2_IR: tap_state_next = tap_f.tms ? JIP_UPD_IR : JIP_SH_IR;
        JIP_UPD_IR: tap_state_next = tap_f.tms ? JIP_SEL_DR : JIP_RTI;
        default: tap_state_next = JIP_TLR;
      endcase
      case (tap_state_reg)
        JIP_TLR:
        begin
          ir_next = JIP_BYPASS;
        end
        JIP_CAP_IR:
        begin
          ir_shift_next = JIP_IR_CAPTURE;
        end
        JIP_SH_IR:
        begin
          ir_shift_next = {tap_f.tdi, ir_shift_reg[7:1]};
        end
        JIP_UPD_IR:
        begin
          // Unknown codes, boundary-scan ones among them, fall back to bypass.
          ir_next = ir_shift_reg;
          if (ir_shift_reg == JIP_ISC_ENABLE)
          begin
            active_next = 1'b1;
            disabled_seen_next = 1'b0;
          end
          else if (ir_shift_reg == JIP_ISC_DISABLE)
          begin
            active_next = 1'b0;
            ext_en_next = 1'b0;
            od_next = 1'b0;
            disabled_seen_next = 1'b1;
          end
          else if (ir_shift_reg == JIP_ISC_CLEAR && active_reg)
          begin
            err_clear = 1'b1;
          end
        end
        JIP_CAP_DR:
        begin
          bypass_next = 1'b0;
          dr_shift_next = {{(JIP_DR_W-2){1'b0}}, error_reg, ~mem_busy};
        end
        JIP_SH_DR:
        begin
          bypass_next = tap_f.tdi;
          dr_shift_next = {tap_f.tdi, dr_shift_reg[JIP_DR_W-1:1]};
        end
        JIP_UPD_DR:
        begin
          if (active_reg && ir_reg == JIP_ISC_ENABLE)
          begin
            ext_en_next = dr_shift_reg[JIP_OPT_EXT_BIT];
            od_next = dr_shift_reg[JIP_OPT_OD_BIT];
          end
          else if (active_reg && !mem_busy && (ir_reg == JIP_ISC_PROGRAM || ir_reg == JIP_ISC_ERASE))
          begin
            prog_cmd_next = jip_prog_cmd_type'(dr_shift_reg);
            prog_req_next = (ir_reg == JIP_ISC_PROGRAM);
            erase_req_next = (ir_reg == JIP_ISC_ERASE);
          end
        end
        default:
        begin
        end
      endcase
    end
    else if (tck_fall)
    begin
      // Serial output changes on the falling test clock edge.
      tdo_drive_next = active_reg & ((tap_state_reg == JIP_SH_DR) | (tap_state_reg == JIP_SH_IR));
      if (tap_state_reg == JIP_SH_IR)
      begin
        tdo_next = ir_shift_reg[0];
      end
      else
      begin
        tdo_next = dr_is_data(ir_reg) ? dr_shift_reg[0] : bypass_reg;
      end
    end
    if (!dev_reset_n && disabled_seen_reg)
    begin
      err_clear = 1'b1;
      disabled_seen_next = 1'b0;
    end
    // A failure in the same cycle as a clear keeps the flag set.
    error_next = prog_fail | (error_reg & ~err_clear);
  end

  // Pin multiplexing and extension outputs.
  always_comb
  begin
    pin_out_next = gpio_out;
    pin_oe_n_next = gpio_oe_n;
    if (port_on)
    begin
      pin_out_next = {tdo_reg, 3'h0};
      pin_oe_n_next = {~tdo_drive_reg, 3'h7};
    end
    st_out_next = 1'b0;
    st_oe_n_next = 1'b1;
    er_out_next = 1'b0;
    er_oe_n_next = 1'b1;
    if (port_on && active_reg && ext_en_reg)
    begin
      st_out_next = od_reg ? 1'b0 : ~mem_busy;
      st_oe_n_next = od_reg ? ~mem_busy : 1'b0;
      er_out_next = od_reg ? 1'b0 : ~error_reg;
      er_oe_n_next = od_reg ? ~error_reg : 1'b0;
    end
  end

  // Registers all state of the block.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      enable_reg <= JIP_ENABLE_RESET[JIP_ENABLE_BIT];
      tck_prev_reg <= 1'b0;
      tap_state_reg <= JIP_TLR;
      ir_shift_reg <= JIP_BYPASS;
      ir_reg <= JIP_BYPASS;
      dr_shift_reg <= '0;
      bypass_reg <= 1'b0;
      active_reg <= 1'b0;
      ext_en_reg <= 1'b0;
      od_reg <= 1'b0;
      tdo_reg <= 1'b0;
      tdo_drive_reg <= 1'b0;
      error_reg <= 1'b0;
      disabled_seen_reg <= 1'b0;
      prog_cmd_reg <= '0;
      prog_req_reg <= 1'b0;
      erase_req_reg <= 1'b0;
      pin_out_reg <= 4'h0;
      pin_oe_n_reg <= 4'hF;
      st_out_reg <= 1'b0;
      st_oe_n_reg <= 1'b1;
      er_out_reg <= 1'b0;
      er_oe_n_reg <= 1'b1;
    end
    else
    begin
      enable_reg <= enable_next;
      tck_prev_reg <= tck_prev_next;
      tap_state_reg <= tap_state_next;
      ir_shift_reg <= ir_shift_next;
      ir_reg <= ir_next;
      dr_shift_reg <= dr_shift_next;
      bypass_reg <= bypass_next;
      active_reg <= active_next;
      ext_en_reg <= ext_en_next;
      od_reg <= od_next;
      tdo_reg <= tdo_next;
      tdo_drive_reg <= tdo_drive_next;
      error_reg <= error_next;
      disabled_seen_reg <= disabled_seen_next;
      prog_cmd_reg <= prog_cmd_next;
      prog_req_reg <= prog_req_next;
      erase_req_reg <= erase_req_next;
      pin_out_reg <= pin_out_next;
      pin_oe_n_reg <= pin_oe_n_next;
      st_out_reg <= st_out_next;
      st_oe_n_reg <= st_oe_n_next;
      er_out_reg <= er_out_next;
      er_oe_n_reg <= er_oe_n_next;
    end
  end

  assign pin_out = pin_out_reg;
  assign pin_oe_n = pin_oe_n_reg;
  assign program_status_out = st_out_reg;
  assign program_status_oe_n = st_oe_n_reg;
  assign program_error_out = er_out_reg;
  assign program_error_oe_n = er_oe_n_reg;
  assign prog_cmd = prog_cmd_reg;
  assign prog_req = prog_req_reg;
  assign erase_req = erase_req_reg;

  // Checks on the port behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_PORT_ON_OR: assert property (port_on |=> pin_oe_n[2:0] == 3'h7) else $error("test pins not inputs");
  AST_TDO_QUIET: assert property (port_on && !active_reg ##1 port_on |=> pin_oe_n[3])
    else $error("tdo driven early");
  AST_GPIO_RELEASE: assert property (!port_on |=> pin_out == $past(gpio_out) && pin_oe_n == $past(gpio_oe_n))
    else $error("pins not released");
  AST_NVM_HOLDS: assert property (nvm_dedicate && !dev_reset_n |=> pin_oe_n[2:0] == 3'h7)
    else $error("dedicated pins lost");
  AST_REG_SET: assert property (reg_hit && reg_wr && reg_wdata[0] && dev_reset_n |=> enable_reg && reg_rdata[0] == io_sel
    || reg_addr != JIP_ENABLE_OFFSET) else $error("enable write lost");
  AST_REG_CLEAR: assert property (!dev_reset_n |=> !enable_reg) else $error("enable not cleared");
  AST_ABORT: assert property (abort |=> tap_state_reg == JIP_TLR && !active_reg) else $error("reset did not abort");
  AST_NO_ABORT: assert property (dedicated && !dev_reset_n && !tck_rise && !tck_fall |=> $stable(tap_state_reg)
    && $stable(active_reg)) else $error("dedicated session aborted");
  AST_ISC_ONLY: assert property ($rose(prog_req) |-> $past(ir_reg) == JIP_ISC_PROGRAM && $past(active_reg))
    else $error("program without command");
  AST_ERR_SET: assert property (prog_fail |=> error_reg ##1 (!program_error_out || program_error_oe_n))
    else $error("error not flagged");
  AST_STATUS_BUSY: assert property (port_on && active_reg && ext_en_reg && mem_busy |=> !program_status_out)
    else $error("status high while busy");
  AST_STATUS_IDLE: assert property (port_on && active_reg && ext_en_reg && !od_reg && !mem_busy |=> program_status_out
    && !program_status_oe_n) else $error("status low while idle");
  AST_OPEN_DRAIN: assert property ($past(od_reg) && !st_oe_n_reg |-> !st_out_reg)
    else $error("open drain drove high");

  COV_ACTIVE: cover property ($rose(active_reg));
  COV_PROG: cover property (prog_req_reg);
  COV_ERASE: cover property (erase_req_reg);
  COV_ERR: cover property ($fell(error_reg));

endmodule
`default_nettype wire

// *** include/jip_pkg.sv ***
package jip_pkg;

  // Run-time enable register, offset from the I/O block base.
  localparam logic [7:0] JIP_ENABLE_OFFSET = 8'hC7;
  localparam int JIP_ENABLE_BIT = 0;
  localparam logic [7:0] JIP_ENABLE_RESET = 8'h00;

  // Instruction register and its codes.
  localparam int JIP_IR_W = 8;
  localparam logic [7:0] JIP_IR_CAPTURE = 8'h01;
  localparam logic [7:0] JIP_ISC_ENABLE = 8'h0C;
  localparam logic [7:0] JIP_ISC_DISABLE = 8'h0F;
  localparam logic [7:0] JIP_ISC_PROGRAM = 8'h1A;
  localparam logic [7:0] JIP_ISC_ERASE = 8'h1B;
  localparam logic [7:0] JIP_ISC_CLEAR = 8'h1C;
  localparam logic [7:0] JIP_BYPASS = 8'hFF;

  // Data register layout: target, address, data byte.
  localparam int JIP_DR_W = 26;
  localparam int JIP_OPT_EXT_BIT = 0;
  localparam int JIP_OPT_OD_BIT = 1;

  // Programming targets.
  localparam logic [1:0] JIP_TGT_PRIMARY = 2'h0;
  localparam logic [1:0] JIP_TGT_SECONDARY = 2'h1;
  localparam logic [1:0] JIP_TGT_LOGIC = 2'h2;
  localparam logic [1:0] JIP_TGT_CONFIG = 2'h3;

  // Number of sampling stages on pin inputs.
  localparam int JIP_SYNC_STAGES = 3;

  typedef enum logic [3:0] {
    JIP_TLR = 4'hF,
    JIP_RTI = 4'hC,
    JIP_SEL_DR = 4'h7,
    JIP_CAP_DR = 4'h6,
    JIP_SH_DR = 4'h2,
    JIP_EX1_DR = 4'h1,
    JIP_PA_DR = 4'h3,
    JIP_EX2_DR = 4'h0,
    JIP_UPD_DR = 4'h5,
    JIP_SEL_IR = 4'h4,
    JIP_CAP_IR = 4'hE,
    JIP_SH_IR = 4'hA,
    JIP_EX1_IR = 4'h9,
    JIP_PA_IR = 4'hB,
    JIP_EX2_IR = 4'h8,
    JIP_UPD_IR = 4'hD
  } jip_tap_state_type;

  typedef struct packed {
    logic tms;
    logic tck;
    logic tdi;
  } jip_tap_pins_type;

  typedef struct packed {
    logic [1:0] target;
    logic [15:0] addr;
    logic [7:0] data;
  } jip_prog_cmd_type;

endpackage

// *** verification/jip_jtag_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behavioural programming controller on the far side of the test pins.
module jip_jtag_ctrl
  import jip_pkg::*;
(
  output var jip_tap_pins_type tap, // Mode, clock and data lines.
  output logic cable_enable_signal, // High while a session runs.
  input wire logic tdo // Serial data from the device.
);
  // The test clock stands low between frames.
  initial
  begin
    tap = '0;
    cable_enable_signal = 1'b0;
  end

  // One test-clock period; data out is sampled late in the high phase.
  task automatic step(input logic tms, input logic tdi, output logic seen);
  begin
    tap.tms = tms;
    tap.tdi = tdi;
    #24;
    tap.tck = 1'b1;
    #24;
    seen = tdo;
    tap.tck = 1'b0;
  end
  endtask

  // Five high mode bits reach the reset state, then idle.
  task automatic tap_reset;
    logic s;
  begin
    cable_enable_signal = 1'b1;
    repeat (5) step(1'b1, 1'b0, s);
    step(1'b0, 1'b0, s);
  end
  endtask

  // Loads an instruction from idle, least significant bit first.
  task automatic load_ir(input logic [7:0] code, output logic [7:0] cap);
    logic s;
  begin
    step(1'b1, 1'b0, s);
    step(1'b1, 1'b0, s);
    step(1'b0, 1'b0, s);
    step(1'b0, 1'b0, s);
    for (int i = 0; i < 8; i++)
      step(i == 7, code[i], cap[i]);
    step(1'b1, 1'b0, s);
    step(1'b0, 1'b0, s);
  end
  endtask

  // Shifts n data bits from idle, least significant bit first.
  task automatic shift_dr(input logic [25:0] v, input int n, output logic [25:0] cap);
    logic s;
  begin
    cap = '0;
    step(1'b1, 1'b0, s);
    step(1'b0, 1'b0, s);
    step(1'b0, 1'b0, s);
    for (int i = 0; i < n; i++)
      step(i == n - 1, v[i], cap[i]);
    step(1'b1, 1'b0, s);
    step(1'b0, 1'b0, s);
  end
  endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
  import jip_pkg::*;
;
  logic clk, rst_n, dev_reset_n, nvm_dedicate, device_blank, pt_sel, io_sel, reg_wr, mem_busy, prog_fail;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cap8;
  logic [3:0] gpio_out, gpio_oe_n, pin_out, pin_oe_n;
  logic st_out, st_oe_n, er_out, er_oe_n, prog_req, erase_req, cable_on, enable_pt, tdo_line;
  jip_tap_pins_type tap;
  jip_prog_cmd_type prog_cmd, cmd;
  logic [25:0] cap26;
  logic [27:0] notes[$];
  int miscompares, comparisons;

  // The product term follows the cable enable while pt_sel is set; a released data line shows the inverse of its last value.
  assign enable_pt = pt_sel & cable_on;
  assign tdo_line = pin_oe_n[3] ? ~pin_out[3] : pin_out[3];

  jip_port u_jip_port (.clk(clk), .rst_n(rst_n), .dev_reset_n(dev_reset_n), .nvm_dedicate(nvm_dedicate),
    .device_blank(device_blank), .enable_product_term(enable_pt), .io_sel(io_sel), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tap_pin_in(tap), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .program_status_out(st_out),
    .program_status_oe_n(st_oe_n), .program_error_out(er_out), .program_error_oe_n(er_oe_n),
    .mem_busy(mem_busy), .prog_fail(prog_fail), .prog_cmd(prog_cmd), .prog_req(prog_req), .erase_req(erase_req));

  jip_jtag_ctrl u_jip_jtag_ctrl (.tap(tap), .cable_enable_signal(cable_on), .tdo(tdo_line));

  // Free-running 200 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
  begin
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  task automatic conclude;
  begin
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  task automatic settle;
    repeat (8) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] d);
  begin
    @(negedge clk);
    io_sel = 1'b1;
    reg_addr = JIP_ENABLE_OFFSET;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  end
  endtask

  // Read data is combinational, so it is looked at within the same cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
  begin
    @(negedge clk);
    io_sel = 1'b1;
    reg_addr = a;
    #1 check("reg_rdata", reg_rdata, exp);
  end
  endtask

  task automatic dev_pulse;
  begin
    @(negedge clk);
    dev_reset_n = 1'b0;
    repeat (3) @(negedge clk);
    dev_reset_n = 1'b1;
  end
  endtask

  task automatic pulse_fail;
  begin
    @(negedge clk);
    prog_fail = 1'b1;
    @(negedge clk);
    prog_fail = 1'b0;
  end
  endtask

  // Each request pulse takes the oldest note off the queue.
  always @(posedge clk)
  begin
    if (prog_req === 1'b1 || erase_req === 1'b1)
    begin
      if (notes.size() == 0)
        check("spurious request", 28'h1, 28'h0);
      else
        check("request", {erase_req, prog_req, prog_cmd}, notes.pop_front());
    end
  end

  // Cuts a hang short.
  initial
  begin
    #300000;
    miscompares++;
    conclude();
  end

  initial
  begin
    {rst_n, nvm_dedicate, device_blank, pt_sel, io_sel, reg_wr, mem_busy, prog_fail} = 8'h00;
    {dev_reset_n, reg_addr, reg_wdata, gpio_out, gpio_oe_n} = {1'b1, 24'h00000F};
    void'($urandom(32'h09F6));
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (3)
    begin
      {gpio_out, gpio_oe_n} = 8'($urandom);
      repeat (3) @(negedge clk);
      check("general pins", {pin_out, pin_oe_n}, {gpio_out, gpio_oe_n});
    end
    gpio_oe_n = 4'h0;
    rd(JIP_ENABLE_OFFSET, JIP_ENABLE_RESET);
    rd(8'hC6, 8'h00);
    wr(8'($urandom) | 8'h01);
    rd(JIP_ENABLE_OFFSET, 8'h01);
    settle();
    check("pin enables", pin_oe_n, 4'hF);
    wr(8'($urandom) & 8'hFE);
    rd(JIP_ENABLE_OFFSET, 8'h00);
    settle();
    check("pins released", pin_oe_n, gpio_oe_n);
    wr(8'h01);
    dev_pulse();
    rd(JIP_ENABLE_OFFSET, 8'h00);
    io_sel = 1'b0;
    u_jip_jtag_ctrl.tap_reset();
    for (int k = 0; k < 3; k++)
    begin
      @(negedge clk);
      {nvm_dedicate, device_blank, pt_sel} = 3'(1 << k);
      settle();
      check("enable term", pin_oe_n, 4'hF);
      @(negedge clk);
      {nvm_dedicate, device_blank, pt_sel} = 3'h0;
    end
    // Product-term session: device reset aborts and then blocks.
    @(negedge clk);
    pt_sel = 1'b1;
    settle();
    u_jip_jtag_ctrl.tap_reset();
    u_jip_jtag_ctrl.load_ir(JIP_ISC_ENABLE, cap8);
    u_jip_jtag_ctrl.shift_dr(26'h1, 26, cap26);
    settle();
    check("status enable", st_oe_n, 1'b0);
    dev_reset_n = 1'b0;
    settle();
    check("aborted status", st_oe_n, 1'b1);
    u_jip_jtag_ctrl.load_ir(JIP_ISC_ENABLE, cap8);
    u_jip_jtag_ctrl.shift_dr(26'h1, 26, cap26);
    settle();
    check("blocked status", st_oe_n, 1'b1);
    dev_reset_n = 1'b1;
    pt_sel = 1'b0;
    nvm_dedicate = 1'b1;
    settle();
    u_jip_jtag_ctrl.tap_reset();
    u_jip_jtag_ctrl.load_ir(JIP_ISC_ENABLE, cap8);
    u_jip_jtag_ctrl.shift_dr(26'h1, 26, cap26);
    settle();
    check("extensions", {st_out, st_oe_n, er_out, er_oe_n}, 4'hA);
    mem_busy = 1'b1;
    settle();
    check("busy status", st_out, 1'b0);
    mem_busy = 1'b0;
    dev_reset_n = 1'b0;
    for (int t = 0; t < 5; t++)
    begin
      cmd = {t[1:0], 16'($urandom), 8'($urandom)};
      notes.push_back({t == 4, t != 4, cmd});
      u_jip_jtag_ctrl.load_ir(t == 4 ? JIP_ISC_ERASE : JIP_ISC_PROGRAM, cap8);
      check("ir capture", cap8, JIP_IR_CAPTURE);
      u_jip_jtag_ctrl.shift_dr(cmd, 26, cap26);
    end
    settle();
    dev_reset_n = 1'b1;
    check("pending requests", 28'(notes.size()), 28'h0);
    u_jip_jtag_ctrl.load_ir(8'h00, cap8);
    cmd = 26'($urandom);
    u_jip_jtag_ctrl.shift_dr(cmd, 8, cap26);
    check("bypass", cap26[7:0], {cmd[6:0], 1'b0});
    pulse_fail();
    settle();
    check("error set", er_out, 1'b0);
    u_jip_jtag_ctrl.load_ir(JIP_ISC_CLEAR, cap8);
    settle();
    check("error cleared", er_out, 1'b1);
    pulse_fail();
    u_jip_jtag_ctrl.load_ir(JIP_ISC_DISABLE, cap8);
    dev_pulse();
    u_jip_jtag_ctrl.load_ir(JIP_ISC_ENABLE, cap8);
    u_jip_jtag_ctrl.shift_dr(26'h3, 26, cap26);
    settle();
    check("open drain idle", {er_out, er_oe_n, st_out, st_oe_n}, 4'h5);
    mem_busy = 1'b1;
    settle();
    check("open drain busy", {st_out, st_oe_n}, 2'h0);
    mem_busy = 1'b0;
    settle();
    conclude();
  end
endmodule
`default_nettype wire
